// *** verilog/irq_controller.sv ***
// Vectored priority interrupt controller with the core entry and return
// sequencer. Assumes same-clock sources, an APB master and a core that
// stalls while core_hold_out is high and answers pops in the same cycle.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module irq_controller #(
  parameter int NUM_SRC = irq_ctrl_pkg::NUM_SRC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [NUM_SRC-1:0] src_post_in,
  input wire logic instr_done_in,
  input wire logic return_from_irq_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] pop_data_in,
  output logic core_hold_out,
  output logic push_valid_out,
  output logic [7:0] push_data_out,
  output logic pop_req_out,
  output logic pc_load_out,
  output logic [15:0] pc_value_out,
  output logic [7:0] vector_out,
  output logic irq_active_out,
  output logic global_irq_enable_out
);

  irq_ctrl_pkg::seq_state_t state_q;
  irq_ctrl_pkg::seq_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] mask_q [3];
  logic soft_en_q;
  logic [7:0] pc_low_q;
  logic [15:0] ret_pc_q;
  logic chain_q;
  logic [7:0] vec_q;
  logic [4:0] vec_idx_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic core_hold_q;
  logic push_valid_q;
  logic [7:0] push_data_q;
  logic pop_req_q;
  logic pc_load_q;
  logic [15:0] pc_value_q;
  logic irq_active_q;

  // APB decode; registers sit at four times their index
  wire [9:0] word_idx = paddr_in[11:2];
  wire apb_setup = psel_in & ~penable_in;
  wire apb_wr = psel_in & penable_in & pready_q & pwrite_in;
  wire hit_clr0 = word_idx == irq_ctrl_pkg::IDX_CLEAR0;
  wire hit_clr1 = word_idx == irq_ctrl_pkg::IDX_CLEAR1;
  wire hit_clr2 = word_idx == irq_ctrl_pkg::IDX_CLEAR2;
  wire hit_msk0 = word_idx == irq_ctrl_pkg::IDX_MASK0;
  wire hit_msk1 = word_idx == irq_ctrl_pkg::IDX_MASK1;
  wire hit_msk2 = word_idx == irq_ctrl_pkg::IDX_MASK2;
  wire hit_soft = word_idx == irq_ctrl_pkg::IDX_SOFT_EN;
  wire hit_stat = word_idx == irq_ctrl_pkg::IDX_STATUS;
  wire hit_flags = word_idx == irq_ctrl_pkg::IDX_FLAGS;
  wire [2:0] hit_clr = {hit_clr2, hit_clr1, hit_clr0};
  wire [2:0] hit_msk = {hit_msk2, hit_msk1, hit_msk0};
  wire hit_any = (|hit_clr) | (|hit_msk) | hit_soft | hit_stat | hit_flags;
  // Status is read-only, so a write to it is refused too
  wire addr_bad = ~hit_any | (pwrite_in & hit_stat);

  // Posted, pending and priority selection
  wire [NUM_SRC-1:0] posted;
  wire [23:0] posted_reg;
  wire [23:0] mask_reg;
  wire [NUM_SRC-1:0] pending;
  wire any_pending;
  wire [4:0] enc_idx;
  wire [7:0] enc_vec;
  wire global_en = flags_q[irq_ctrl_pkg::GLOBAL_EN_BIT];

  // Register bit k stands for priority k+1; priority 0 is reset
  assign posted_reg = {posted[NUM_SRC-1:1], 1'b0} >> 1;
  assign mask_reg = {mask_q[2], mask_q[1], mask_q[0]};
  // Mask only gates pending; posting is never blocked by it
  assign pending = posted & {mask_reg[NUM_SRC-2:0], 1'b0};

  irq_prio_encoder #(
    .N(NUM_SRC)
  ) u_enc (
    .pending_in(pending),
    .any_out(any_pending),
    .index_out(enc_idx),
    .vector_out(enc_vec)
  );

  // Clear-register writes: zero clears, or one posts when soft enabled
  wire [23:0] sw_clr_reg;
  wire [23:0] sw_set_reg;
  genvar r;
  generate
    for (r = 0; r < 3; r++)
    begin : g_clr_wr
      wire wr_hit = apb_wr & hit_clr[r];
      assign sw_clr_reg[8*r+7:8*r] =
        (wr_hit & ~soft_en_q) ? ~pwdata_in[7:0] : 8'h00;
      assign sw_set_reg[8*r+7:8*r] =
        (wr_hit & soft_en_q) ? pwdata_in[7:0] : 8'h00;
    end
  endgenerate

  // Sequencer control terms
  wire irq_go = global_en & any_pending;
  wire take = (state_q == irq_ctrl_pkg::SEQ_IDLE) & ~return_from_irq_in &
    instr_done_in & irq_go;
  wire ret_last = (state_q == irq_ctrl_pkg::SEQ_RETURN) &
    (cnt_q == irq_ctrl_pkg::POP_LAST);
  wire chain = ret_last & irq_go;
  wire start_entry = take | chain;
  wire in_entry = state_q == irq_ctrl_pkg::SEQ_ENTRY;
  wire in_ret = state_q == irq_ctrl_pkg::SEQ_RETURN;
  wire [15:0] pc_src = chain_q ? ret_pc_q : pc_in;

  // Vector fetch at entry start clears only the serviced source
  wire [NUM_SRC-1:0] serv_clr =
    start_entry ? (NUM_SRC'(1) << enc_idx) : '0;
  wire [NUM_SRC-1:0] post_set =
    src_post_in | {sw_set_reg[NUM_SRC-2:0], 1'b0};
  wire [NUM_SRC-1:0] post_clr = serv_clr | {sw_clr_reg[NUM_SRC-2:0], 1'b0};

  irq_post_bank #(
    .N(NUM_SRC)
  ) u_post (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .set_in(post_set),
    .clear_in(post_clr),
    .posted_out(posted)
  );

  // Read data mux
  wire [7:0] status_byte = {1'b0, state_q, vec_idx_q};
  wire [7:0] rd_byte =
    hit_clr0 ? posted_reg[7:0] :
    hit_clr1 ? posted_reg[15:8] :
    hit_clr2 ? posted_reg[23:16] :
    hit_msk0 ? mask_q[0] :
    hit_msk1 ? mask_q[1] :
    hit_msk2 ? mask_q[2] :
    hit_soft ? {7'h00, soft_en_q} :
    hit_stat ? status_byte :
    hit_flags ? flags_q : 8'h00;

  // Zero wait states; ready is registered from the setup cycle so read data comes from a flop
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & addr_bad;
      prdata_q <= (apb_setup & ~pwrite_in) ? {24'h000000, rd_byte} :
        32'h0000_0000;
    end
  end

  // Mask and soft-enable registers; a set mask bit enables its source
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      mask_q[0] <= irq_ctrl_pkg::MASK_RST;
      mask_q[1] <= irq_ctrl_pkg::MASK_RST;
      mask_q[2] <= irq_ctrl_pkg::MASK_RST;
      soft_en_q <= irq_ctrl_pkg::SOFT_EN_RST;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (apb_wr & hit_msk[i])
          mask_q[i] <= pwdata_in[7:0];
      end
      if (apb_wr & hit_soft)
        soft_en_q <= pwdata_in[irq_ctrl_pkg::SOFT_EN_BIT];
    end
  end

  // Flag register: entry clear beats restore beats software write
  always_comb
  begin
    flags_d = flags_q;
    if (apb_wr & hit_flags)
      flags_d = pwdata_in[7:0];
    if (in_ret & pop_req_q & (cnt_q == irq_ctrl_pkg::POP_FLAGS))
      flags_d = pop_data_in;
    if (in_entry & (cnt_q == irq_ctrl_pkg::PUSH_FLAGS))
      flags_d = irq_ctrl_pkg::FLAGS_RST;
  end

  // Sequencer next state; a return at a boundary wins over a take
  always_comb
  begin
    state_d = state_q;
    cnt_d = 4'(cnt_q + 4'h1);
    case (state_q)
      irq_ctrl_pkg::SEQ_IDLE:
      begin
        cnt_d = 4'h0;
        if (return_from_irq_in)
          state_d = irq_ctrl_pkg::SEQ_RETURN;
        else if (take)
          state_d = irq_ctrl_pkg::SEQ_ENTRY;
      end
      irq_ctrl_pkg::SEQ_ENTRY:
      begin
        if (cnt_q == irq_ctrl_pkg::ENTRY_LAST)
          state_d = irq_ctrl_pkg::SEQ_IDLE;
      end
      irq_ctrl_pkg::SEQ_RETURN:
      begin
        if (ret_last)
        begin
          cnt_d = 4'h0;
          state_d = chain ? irq_ctrl_pkg::SEQ_ENTRY :
            irq_ctrl_pkg::SEQ_IDLE;
        end
      end
      default:
      begin
        state_d = irq_ctrl_pkg::SEQ_IDLE;
        cnt_d = 4'h0;
      end
    endcase
  end

  // Sequencer state, saved vector and restored PC
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= irq_ctrl_pkg::SEQ_IDLE;
      cnt_q <= 4'h0;
      flags_q <= irq_ctrl_pkg::FLAGS_RST;
      vec_q <= 8'h00;
      vec_idx_q <= 5'h00;
      pc_low_q <= 8'h00;
      ret_pc_q <= 16'h0000;
      chain_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      flags_q <= flags_d;
      if (start_entry)
      begin
        vec_q <= enc_vec;
        vec_idx_q <= enc_idx;
      end
      if (in_ret & pop_req_q & (cnt_q == irq_ctrl_pkg::POP_LO))
        pc_low_q <= pop_data_in;
      if (ret_last)
        ret_pc_q <= {pop_data_in, pc_low_q};
      // Chained entry pushes the restored PC, not the core's stale one
      if (chain)
        chain_q <= 1'b1;
      else if (state_d == irq_ctrl_pkg::SEQ_IDLE)
        chain_q <= 1'b0;
    end
  end

  // Core-facing strobes, each delayed one cycle from its count; core_hold_q follows state_d
  wire push_now = in_entry & (cnt_q <= irq_ctrl_pkg::PUSH_FLAGS);
  wire [7:0] push_byte =
    (cnt_q == irq_ctrl_pkg::PUSH_HI) ? pc_src[15:8] :
    (cnt_q == irq_ctrl_pkg::PUSH_LO) ? pc_src[7:0] : flags_q;
  wire entry_load = in_entry & (cnt_q == irq_ctrl_pkg::ENTRY_LAST);
  // Vector slot then runs the seven-cycle long jump on the core side
  wire [15:0] load_value =
    entry_load ? {8'h00, vec_q} : {pop_data_in, pc_low_q};

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      core_hold_q <= 1'b0;
      push_valid_q <= 1'b0;
      push_data_q <= 8'h00;
      pop_req_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_value_q <= 16'h0000;
      irq_active_q <= 1'b0;
    end
    else
    begin
      core_hold_q <= state_d != irq_ctrl_pkg::SEQ_IDLE;
      push_valid_q <= push_now;
      push_data_q <= push_now ? push_byte : 8'h00;
      pop_req_q <= in_ret & (cnt_q < irq_ctrl_pkg::POP_LAST) &
        (cnt_d <= irq_ctrl_pkg::POP_LAST);
      pc_load_q <= entry_load | ret_last;
      pc_value_q <= (entry_load | ret_last) ? load_value : 16'h0000;
      irq_active_q <= irq_go;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign core_hold_out = core_hold_q;
  assign push_valid_out = push_valid_q;
  assign push_data_out = push_data_q;
  assign pop_req_out = pop_req_q;
  assign pc_load_out = pc_load_q;
  assign pc_value_out = pc_value_q;
  assign vector_out = vec_q;
  assign irq_active_out = irq_active_q;
  assign global_irq_enable_out = flags_q[irq_ctrl_pkg::GLOBAL_EN_BIT];

endmodule : irq_controller

// *** inc/irq_ctrl_pkg.sv ***
// Constants shared by the vectored interrupt controller and its helpers.
// Assumes one 50 MHz system clock and a 32-bit APB register port.
package irq_ctrl_pkg;

  // Source count: priority 0 is reset, 1..23 are hardware sources
  localparam int NUM_SRC = 24;
  localparam int VEC_W = 8;

  // Clear register indices; byte address is four times these
  localparam logic [9:0] IDX_CLEAR0 = 10'h0DA;
  localparam logic [9:0] IDX_CLEAR1 = 10'h0DB;
  localparam logic [9:0] IDX_CLEAR2 = 10'h0DC;
  // Further register indices
  localparam logic [9:0] IDX_MASK0 = 10'h0E0;
  localparam logic [9:0] IDX_MASK1 = 10'h0E1;
  localparam logic [9:0] IDX_MASK2 = 10'h0E2;
  localparam logic [9:0] IDX_SOFT_EN = 10'h0E3;
  localparam logic [9:0] IDX_STATUS = 10'h0E4;
  localparam logic [9:0] IDX_FLAGS = 10'h0F7;

  // Field positions and reset values
  localparam int GLOBAL_EN_BIT = 0;
  localparam int SOFT_EN_BIT = 0;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic SOFT_EN_RST = 1'b0;

  // Entry and return sequence timing in CPU clock cycles
  localparam int ENTRY_CYCLES = 13;
  localparam logic [3:0] ENTRY_LAST = 4'(ENTRY_CYCLES - 1);
  localparam logic [3:0] PUSH_HI = 4'h0;
  localparam logic [3:0] PUSH_LO = 4'h1;
  localparam logic [3:0] PUSH_FLAGS = 4'h2;
  localparam logic [3:0] POP_FLAGS = 4'h1;
  localparam logic [3:0] POP_LO = 4'h2;
  localparam logic [3:0] POP_LAST = 4'h3;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ENTRY = 2'b01,
    SEQ_RETURN = 2'b10
  } seq_state_t;

endpackage : irq_ctrl_pkg

// *** verilog/irq_prio_encoder.sv ***
// Fixed-priority encoder: lowest index wins, vector is four times it.
// Assumes pending bits come from logic on the same clock.
`timescale 1ns/1ps
module irq_prio_encoder #(
  parameter int N = 24
) (
  input wire logic [N-1:0] pending_in,
  output logic any_out,
  output logic [4:0] index_out,
  output logic [7:0] vector_out
);

  // Scan from lowest priority upward so the smallest index is kept last
  always_comb
  begin
    index_out = 5'h00;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (pending_in[i])
      begin
        index_out = 5'(i);
      end
    end
  end

  assign any_out = |pending_in;
  assign vector_out = {1'b0, index_out, 2'b00};

endmodule : irq_prio_encoder

// *** verilog/irq_post_bank.sv ***
// Bank of posted-interrupt flip-flops, one per priority level from 1 up.
// Assumes set and clear vectors from logic on the same clock.
`timescale 1ns/1ps
module irq_post_bank #(
  parameter int N = 24
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [N-1:0] set_in,
  input wire logic [N-1:0] clear_in,
  output logic [N-1:0] posted_out
);

  genvar g;

  // Level 0 is reset and never posts
  assign posted_out[0] = 1'b0;

  generate
    for (g = 1; g < N; g++)
    begin : g_post
      logic post_q;
      // A new post wins over a clear in the same cycle
      always_ff @(posedge sys_clk_in)
      begin
        if (!rst_n_in)
          post_q <= 1'b0;
        else
          post_q <= set_in[g] | (post_q & ~clear_in[g]);
      end
      assign posted_out[g] = post_q;
    end
  endgenerate

endmodule : irq_post_bank

// *** test/irq_props_properties.sv ***
// Checker for the interrupt controller's entry and return sequences.
// Sees only the top-level ports; bound into every controller instance.
`timescale 1ns/1ps
module irq_props (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic instr_done_in,
  input wire logic core_hold_out,
  input wire logic push_valid_out,
  input wire logic pop_req_out,
  input wire logic pc_load_out,
  input wire logic [15:0] pc_value_out,
  input wire logic [7:0] vector_out,
  input wire logic irq_active_out,
  input wire logic global_irq_enable_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Entry is anchored on the first push, which is cycle one
  entry_len_a: assert property ($rose(push_valid_out) |->
    (!pc_load_out) [*8] ##1 (!pc_load_out) [*4] ##1 pc_load_out)
    else $error("entry length wrong");
  entry_pc_a: assert property ($rose(push_valid_out) |->
    ##12 pc_value_out == {8'h00, vector_out})
    else $error("entry pc wrong");
  push_three_a: assert property ($rose(push_valid_out) |->
    push_valid_out [*3] ##1 !push_valid_out)
    else $error("push count wrong");
  gie_drop_a: assert property ($rose(push_valid_out) |->
    ##3 !global_irq_enable_out)
    else $error("global enable kept");
  hold_span_a: assert property ($rose(push_valid_out) |->
    core_hold_out [*8])
    else $error("core not held");
  // Vector table slots are word spaced, lowest priority at the top
  vec_form_a: assert property (vector_out[1:0] == 2'b00 &&
    vector_out <= 8'h5C)
    else $error("vector out of table");
  // Chained entry follows the return's load, never a bare cycle
  entry_cause_a: assert property ($rose(push_valid_out) |->
    $past(instr_done_in, 2) || $past(pc_load_out))
    else $error("entry without boundary");
  pop_seq_a: assert property ($rose(pop_req_out) |->
    pop_req_out [*3] ##1 (pc_load_out && !pop_req_out))
    else $error("return pops wrong");
  irq_gate_a: assert property (irq_active_out |->
    $past(global_irq_enable_out))
    else $error("active while disabled");
endmodule : irq_props

bind irq_controller irq_props u_irq_props (
  .sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in),
  .instr_done_in(instr_done_in),
  .core_hold_out(core_hold_out),
  .push_valid_out(push_valid_out),
  .pop_req_out(pop_req_out),
  .pc_load_out(pc_load_out),
  .pc_value_out(pc_value_out),
  .vector_out(vector_out),
  .irq_active_out(irq_active_out),
  .global_irq_enable_out(global_irq_enable_out)
);

// *** test/core_model.sv ***
// Behavioural processor core: instruction boundaries, stack and PC.
// Assumes the controller's stall, push, pop and load pulses.
`timescale 1ns/1ps
module core_model (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic ret_cmd_in,
  input wire logic core_hold_in,
  input wire logic push_valid_in,
  input wire logic [7:0] push_data_in,
  input wire logic pop_req_in,
  input wire logic pc_load_in,
  input wire logic [15:0] pc_value_in,
  output logic instr_done_out,
  output logic return_from_irq_out,
  output logic [15:0] pc_out,
  output logic [7:0] pop_data_out
);
  logic [7:0] stk_q [0:7];
  logic [2:0] sp_q;
  wire logic [7:0] top = stk_q[sp_q - 3'h1];

  // Off a pop the line shows the inverse, so stale data never matches
  assign pop_data_out = pop_req_in ? top : ~top;

  // Two-cycle instructions; a stall freezes boundaries
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      sp_q <= 3'h0;
      pc_out <= 16'h1200;
      instr_done_out <= 1'b0;
      return_from_irq_out <= 1'b0;
    end
    else
    begin
      instr_done_out <= !core_hold_in && !instr_done_out &&
        !ret_cmd_in && !return_from_irq_out;
      return_from_irq_out <= ret_cmd_in && !core_hold_in &&
        !return_from_irq_out;
      if (push_valid_in)
      begin
        stk_q[sp_q] <= push_data_in;
        sp_q <= sp_q + 3'h1;
      end
      else if (pop_req_in)
        sp_q <= sp_q - 3'h1;
      if (pc_load_in)
        pc_out <= pc_value_in;
      else if (instr_done_out)
        pc_out <= pc_out + 16'h0001;
    end
  end
endmodule : core_model

// *** test/tb.sv ***
// Self-checking bench: APB master, source pulses and the core model.
// Assumes the controller's zero-wait APB answer and entry timing.
`timescale 1ns/1ps
module tb;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [23:0] src_post = 24'h0;
  logic ret_cmd = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, instr_done, ret_pulse, hold, push_v, pop_req;
  wire logic pc_load, active, gl_en;
  wire logic [15:0] pc, pc_val;
  wire logic [7:0] pop_data, push_d, vec;
  int error_cnt = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic er;
  logic [15:0] v;

  irq_controller u_irq_controller (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .src_post_in(src_post), .instr_done_in(instr_done),
    .return_from_irq_in(ret_pulse),
    .pc_in(pc), .pop_data_in(pop_data), .core_hold_out(hold),
    .push_valid_out(push_v), .push_data_out(push_d),
    .pop_req_out(pop_req), .pc_load_out(pc_load), .pc_value_out(pc_val),
    .vector_out(vec), .irq_active_out(active),
    .global_irq_enable_out(gl_en));
  core_model u_core_model (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .ret_cmd_in(ret_cmd), .core_hold_in(hold), .push_valid_in(push_v),
    .push_data_in(push_d), .pop_req_in(pop_req), .pc_load_in(pc_load),
    .pc_value_in(pc_val), .instr_done_out(instr_done),
    .return_from_irq_out(ret_pulse),
    .pc_out(pc), .pop_data_out(pop_data));

  always #10 sys_clk_in = ~sys_clk_in;

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  // One APB transfer; read data taken at the ready edge only
  task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    // A bus that never answers is a failure, not a silent pass
    if (pready !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: no bus answer", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input logic [9:0] i, input logic [31:0] e);
    apb(1'b0, i, 8'h00);
    chk(rd, e);
  endtask : rchk

  task post(input logic [23:0] m);
    @(posedge sys_clk_in);
    src_post <= m;
    @(posedge sys_clk_in);
    src_post <= 24'h0;
  endtask : post

  // Bounded wait for the next PC load
  task wait_load;
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (pc_load !== 1'b1 && n < 100);
    if (pc_load !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: no pc load", $time);
    end
    v = pc_val;
  endtask : wait_load

  task ret;
    @(posedge sys_clk_in);
    ret_cmd <= 1'b1;
    @(posedge sys_clk_in);
    ret_cmd <= 1'b0;
    wait_load;
  endtask : ret

  task t_reset;
    rchk(irq_ctrl_pkg::IDX_FLAGS, 32'h0);
    rchk(irq_ctrl_pkg::IDX_MASK0, 32'h0);
    rchk(irq_ctrl_pkg::IDX_SOFT_EN, 32'h0);
    rchk(irq_ctrl_pkg::IDX_CLEAR0, 32'h0);
    apb(1'b0, 10'h0D0, 8'h00);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, irq_ctrl_pkg::IDX_STATUS, 8'hFF);
    chk({31'h0, er}, 32'h1);
    $display("test reset done");
  endtask : t_reset

  task t_mask;
    post(24'h000020);
    rchk(irq_ctrl_pkg::IDX_CLEAR0, 32'h10);
    apb(1'b1, irq_ctrl_pkg::IDX_FLAGS, 8'h01);
    repeat (4) @(posedge sys_clk_in);
    chk({31'h0, active}, 32'h0);
    post(24'h000020);
    rchk(irq_ctrl_pkg::IDX_CLEAR0, 32'h10);
    apb(1'b1, irq_ctrl_pkg::IDX_MASK0, 8'h10);
    wait_load;
    chk({16'h0, v}, 32'h0014);
    rchk(irq_ctrl_pkg::IDX_CLEAR0, 32'h0);
    rchk(irq_ctrl_pkg::IDX_FLAGS, 32'h0);
    ret;
    chk({24'h0, v[15:8]}, 32'h12);
    rchk(irq_ctrl_pkg::IDX_FLAGS, 32'h1);
    $display("test mask done");
  endtask : t_mask

  task t_prio;
    apb(1'b1, irq_ctrl_pkg::IDX_FLAGS, 8'h00);
    apb(1'b1, irq_ctrl_pkg::IDX_MASK0, 8'h02);
    apb(1'b1, irq_ctrl_pkg::IDX_MASK1, 8'h01);
    post(24'h000204);
    rchk(irq_ctrl_pkg::IDX_CLEAR1, 32'h01);
    apb(1'b1, irq_ctrl_pkg::IDX_FLAGS, 8'h01);
    wait_load;
    chk({16'h0, v}, 32'h0008);
    ret;
    chk({24'h0, v[15:8]}, 32'h12);
    wait_load;
    chk({16'h0, v}, 32'h0024);
    apb(1'b1, irq_ctrl_pkg::IDX_MASK0, 8'h03);
    post(24'h000002);
    apb(1'b1, irq_ctrl_pkg::IDX_FLAGS, 8'h01);
    wait_load;
    chk({16'h0, v}, 32'h0004);
    ret;
    chk({24'h0, v[15:8]}, 32'h00);
    ret;
    chk({24'h0, v[15:8]}, 32'h12);
    $display("test priority done");
  endtask : t_prio

  task t_soft;
    apb(1'b1, irq_ctrl_pkg::IDX_FLAGS, 8'h00);
    post(24'h000002);
    apb(1'b1, irq_ctrl_pkg::IDX_CLEAR0, 8'hFF);
    rchk(irq_ctrl_pkg::IDX_CLEAR0, 32'h01);
    apb(1'b1, irq_ctrl_pkg::IDX_CLEAR0, 8'hFE);
    rchk(irq_ctrl_pkg::IDX_CLEAR0, 32'h00);
    apb(1'b1, irq_ctrl_pkg::IDX_SOFT_EN, 8'h01);
    apb(1'b1, irq_ctrl_pkg::IDX_CLEAR0, 8'h04);
    rchk(irq_ctrl_pkg::IDX_CLEAR0, 32'h04);
    apb(1'b1, irq_ctrl_pkg::IDX_CLEAR0, 8'h00);
    rchk(irq_ctrl_pkg::IDX_CLEAR0, 32'h04);
    // Source held high across a zero write: the post must survive
    apb(1'b1, irq_ctrl_pkg::IDX_SOFT_EN, 8'h00);
    src_post <= 24'h000010;
    apb(1'b1, irq_ctrl_pkg::IDX_CLEAR0, 8'h00);
    src_post <= 24'h000000;
    rchk(irq_ctrl_pkg::IDX_CLEAR0, 32'h08);
    $display("test soft done");
  endtask : t_soft

  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // Main sequence after a 16-cycle reset
  initial
  begin
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_mask;
    t_prio;
    t_soft;
    complete_run;
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    error_cnt++;
    complete_run;
  end
endmodule : tb
